// ==== hdl/ctb_pkg.sv ====
// ****************************************************************
// Shared constants and types
// ****************************************************************
package ctb_pkg;

    localparam int          CTB_W         = 32;
    localparam int          CTB_SPR_W     = 10;

    // Special register numbers
    localparam logic [9:0]  SPR_DOWN_CNT  = 10'h016;
    localparam logic [9:0]  SPR_TBL_RD    = 10'h10C;
    localparam logic [9:0]  SPR_TBU_RD    = 10'h10D;
    localparam logic [9:0]  SPR_TBL_WR    = 10'h11C;
    localparam logic [9:0]  SPR_TBU_WR    = 10'h11D;
    localparam logic [9:0]  SPR_RELOAD    = 10'h200;
    localparam logic [9:0]  SPR_TCTRL     = 10'h201;
    localparam logic [9:0]  SPR_TSTAT     = 10'h202;
    localparam logic [9:0]  SPR_HWCFG     = 10'h203;

    // Field positions
    localparam int          TCTRL_ARE_BIT = 0;
    localparam int          TCTRL_DIE_BIT = 1;
    localparam int          TSTAT_DIS_BIT = 0;
    localparam int          HWCFG_EN_BIT  = 0;
    localparam int          HWCFG_SEL_LO  = 1;

    // Tick source selections
    localparam logic [1:0]  SRC_CLOCK     = 2'h0;
    localparam logic [1:0]  SRC_DIV_A     = 2'h1;
    localparam logic [1:0]  SRC_DIV_B     = 2'h2;
    localparam logic [1:0]  SRC_EXT       = 2'h3;
    localparam logic [4:0]  DIV_A_LAST    = 5'h03;
    localparam logic [4:0]  DIV_B_LAST    = 5'h1F;

    localparam logic [31:0] ONE_32        = 32'h0000_0001;
    localparam logic [31:0] ZERO_32       = 32'h0000_0000;
    localparam logic [31:0] ONES_32       = 32'hFFFF_FFFF;
    localparam logic [63:0] ONE_64        = 64'h0000_0000_0000_0001;
    localparam logic [4:0]  DIV_STEP      = 5'h01;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        priv;
        logic [9:0]  num;
        logic [31:0] wdata;
    } ctb_spr_req_t;

    typedef struct packed {
        logic [31:0] time_base_upper_half;
        logic [31:0] time_base_lower_half;
        logic [31:0] dec;
        logic [31:0] down_counter_reload_value;
        logic        tick_en;
        logic [1:0]  tick_sel;
        logic        are;
        logic        down_counter_irq_enable;
        logic        dis;
        logic [4:0]  div_cnt;
        logic        ext_d;
        logic [31:0] rdata;
        logic        rvalid;
        logic        irq;
    } ctb_state_t;

endpackage

// ==== hdl/ctb_time_base.sv ====
// How it works
// - Upper and lower halves form 64-bit count
// - Enable bit gates time base and decrementer
// - One shared tick, rate from select field
// - Each tick adds one, unsigned
// - Lower all ones carries into upper half
// - Full wrap to zero, no indication
// - Reads never disturb counting
// - Privileged write replaces the half written
// - Counters undefined at power-on, kept on reset
// - Read values never decrease except wrap
// - Repeated reads may return equal values
// - Tick rate stays under software control
// - Down counter steps per tick, signals event
// - Auto-reload copies reload value at one-to-zero
// - Writing zero raises no event
// - Down counter and reload value are accessible
// - Event sets flag; irq needs both enables
// - Flag cleared only by writing one or by reset
`timescale 1ns/100ps
`default_nettype none

module ctb_time_base (
    // Clock and reset
    input  wire logic                  MCLK,
    input  wire logic                  RESET,
    // Special register moves
    input  wire ctb_pkg::ctb_spr_req_t SPR_REQ,
    output var  logic [31:0]           SPR_RDATA,
    output var  logic                  SPR_RVALID,
    // Tick source and interrupt
    input  wire logic                  TICK_IN,
    input  wire logic                  EXT_IRQ_EN,
    output var  logic                  DEC_IRQ
);
    import ctb_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    ctb_state_t  st_r;
    ctb_state_t  st_nxt;
    logic        tick;
    logic        src_hit;
    logic        dec_event;
    logic        wr_ok;
    logic [63:0] tb_sum;

    function automatic logic spr_hit(input ctb_spr_req_t req, input logic [9:0] num);
        spr_hit = req.num == num;
    endfunction

    function automatic logic src_ready(input logic [1:0] sel, input logic [4:0] cnt,
                                       input logic ext_now, input logic ext_d);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            SRC_CLOCK: hit = 1'b1;
            SRC_DIV_A: hit = (cnt & DIV_A_LAST) == DIV_A_LAST;
            SRC_DIV_B: hit = cnt == DIV_B_LAST;
            SRC_EXT:   hit = ext_now & ~ext_d;
        endcase
        src_ready = hit;
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt     = st_r;
        wr_ok      = SPR_REQ.wr & SPR_REQ.priv;
        st_nxt.div_cnt = st_r.div_cnt + DIV_STEP;
        st_nxt.ext_d   = TICK_IN;
        src_hit    = src_ready(st_r.tick_sel, st_r.div_cnt, TICK_IN, st_r.ext_d);
        tick       = st_r.tick_en & src_hit;
        dec_event  = 1'b0;
        tb_sum     = {st_r.time_base_upper_half, st_r.time_base_lower_half} + ONE_64;
        if (tick) begin
            st_nxt.time_base_upper_half = tb_sum[63:32];
            st_nxt.time_base_lower_half = tb_sum[31:0];
            if (st_r.dec == ONE_32) begin
                dec_event  = 1'b1;
                st_nxt.dec = st_r.are ? st_r.down_counter_reload_value : ZERO_32;
            end else if (st_r.dec != ZERO_32) begin
                st_nxt.dec = st_r.dec - ONE_32;
            end
        end
        if (wr_ok) begin
            if (spr_hit(SPR_REQ, SPR_TBL_WR)) begin
                st_nxt.time_base_lower_half = SPR_REQ.wdata;
            end
            if (spr_hit(SPR_REQ, SPR_TBU_WR)) begin
                st_nxt.time_base_upper_half = SPR_REQ.wdata;
            end
            if (spr_hit(SPR_REQ, SPR_DOWN_CNT)) begin
                st_nxt.dec = SPR_REQ.wdata;
                dec_event  = 1'b0;
            end
            if (spr_hit(SPR_REQ, SPR_RELOAD)) begin
                st_nxt.down_counter_reload_value = SPR_REQ.wdata;
            end
            if (spr_hit(SPR_REQ, SPR_TCTRL)) begin
                st_nxt.are = SPR_REQ.wdata[TCTRL_ARE_BIT];
                st_nxt.down_counter_irq_enable = SPR_REQ.wdata[TCTRL_DIE_BIT];
            end
            if (spr_hit(SPR_REQ, SPR_HWCFG)) begin
                st_nxt.tick_en  = SPR_REQ.wdata[HWCFG_EN_BIT];
                st_nxt.tick_sel = SPR_REQ.wdata[HWCFG_SEL_LO +: 2];
            end
            if (spr_hit(SPR_REQ, SPR_TSTAT) && SPR_REQ.wdata[TSTAT_DIS_BIT]) begin
                st_nxt.dis = 1'b0;
            end
        end
        if (dec_event) begin
            st_nxt.dis = 1'b1;
        end
        // Read path samples current values; counting is untouched
        st_nxt.rvalid = SPR_REQ.rd;
        st_nxt.rdata  = ZERO_32;
        if (SPR_REQ.rd) begin
            unique case (SPR_REQ.num)
                SPR_TBL_RD:   st_nxt.rdata = st_r.time_base_lower_half;
                SPR_TBU_RD:   st_nxt.rdata = st_r.time_base_upper_half;
                SPR_DOWN_CNT: st_nxt.rdata = st_r.dec;
                SPR_RELOAD:   st_nxt.rdata = st_r.down_counter_reload_value;
                SPR_TCTRL: begin
                    st_nxt.rdata[TCTRL_ARE_BIT] = st_r.are;
                    st_nxt.rdata[TCTRL_DIE_BIT] = st_r.down_counter_irq_enable;
                end
                SPR_TSTAT:    st_nxt.rdata[TSTAT_DIS_BIT] = st_r.dis;
                SPR_HWCFG: begin
                    st_nxt.rdata[HWCFG_EN_BIT]         = st_r.tick_en;
                    st_nxt.rdata[HWCFG_SEL_LO +: 2]    = st_r.tick_sel;
                end
                default:      st_nxt.rdata = ZERO_32;
            endcase
        end
        st_nxt.irq = st_nxt.dis & st_nxt.down_counter_irq_enable & EXT_IRQ_EN;
        // Reset clears control, flag, divider, read and irq state; time base, down counter and reload keep their contents
        if (RESET) begin
            st_nxt.tick_en  = 1'b0;
            st_nxt.tick_sel = SRC_CLOCK;
            st_nxt.are      = 1'b0;
            st_nxt.down_counter_irq_enable      = 1'b0;
            st_nxt.dis      = 1'b0;
            st_nxt.div_cnt  = '0;
            st_nxt.ext_d    = 1'b0;
            st_nxt.rdata    = ZERO_32;
            st_nxt.rvalid   = 1'b0;
            st_nxt.irq      = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        st_r <= st_nxt;
    end

    assign SPR_RDATA  = st_r.rdata;
    assign SPR_RVALID = st_r.rvalid;
    assign DEC_IRQ    = st_r.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    logic tb_wr;
    logic dec_wr;
    logic clr_wr;
    assign tb_wr  = wr_ok & (spr_hit(SPR_REQ, SPR_TBL_WR) | spr_hit(SPR_REQ, SPR_TBU_WR));
    assign dec_wr = wr_ok & spr_hit(SPR_REQ, SPR_DOWN_CNT);
    assign clr_wr = wr_ok & spr_hit(SPR_REQ, SPR_TSTAT) & SPR_REQ.wdata[TSTAT_DIS_BIT];

    // Halves hold no defined value until software has written them
    logic tbl_known_r;
    logic tbu_known_r;
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tbl_known_r <= 1'b0;
            tbu_known_r <= 1'b0;
        end else begin
            if (wr_ok && spr_hit(SPR_REQ, SPR_TBL_WR)) begin
                tbl_known_r <= 1'b1;
            end
            if (wr_ok && spr_hit(SPR_REQ, SPR_TBU_WR)) begin
                tbu_known_r <= 1'b1;
            end
        end
    end

    tb_carry_a: assert property (tick && !tb_wr && st_r.time_base_lower_half == ONES_32 && st_r.time_base_upper_half != ONES_32
        |=> st_r.time_base_lower_half == ZERO_32 && st_r.time_base_upper_half == $past(st_r.time_base_upper_half) + ONE_32)
        else $error("lower half carry did not reach upper half");
    tb_wrap_a: assert property (tick && !tb_wr && {st_r.time_base_upper_half, st_r.time_base_lower_half} == {ONES_32, ONES_32}
        |=> {st_r.time_base_upper_half, st_r.time_base_lower_half} == 64'h0 && st_r.dis == $past(st_nxt.dis))
        else $error("full count did not wrap quietly");
    tb_rise_a: assert property (tick && !tb_wr && {st_r.time_base_upper_half, st_r.time_base_lower_half} != {ONES_32, ONES_32}
        |=> {st_r.time_base_upper_half, st_r.time_base_lower_half} == $past({st_r.time_base_upper_half, st_r.time_base_lower_half}) + ONE_64)
        else $error("time base did not advance by one");
    tb_hold_a: assert property (tbl_known_r && tbu_known_r && !st_r.tick_en && !tb_wr
        |=> $stable({st_r.time_base_upper_half, st_r.time_base_lower_half}))
        else $error("time base moved while disabled");
    tb_write_a: assert property (wr_ok && spr_hit(SPR_REQ, SPR_TBL_WR)
        |=> st_r.time_base_lower_half == $past(SPR_REQ.wdata))
        else $error("lower half write lost");
    dec_reload_a: assert property (tick && !dec_wr && st_r.dec == ONE_32 && st_r.are
        |=> st_r.dec == $past(st_r.down_counter_reload_value) && st_r.dis)
        else $error("reload or event missing at one to zero");
    dec_halt_a: assert property (st_r.dec == ZERO_32 && !dec_wr |=> st_r.dec == ZERO_32)
        else $error("down counter left zero without a write");
    dec_zero_a: assert property (dec_wr && !st_r.dis |=> !st_r.dis)
        else $error("write raised a down counter event");
    flag_clear_a: assert property (st_r.dis && !clr_wr |=> st_r.dis)
        else $error("flag dropped without a one written");
    irq_gate_a: assert property (##1 DEC_IRQ == (st_r.dis && st_r.down_counter_irq_enable && $past(EXT_IRQ_EN)))
        else $error("interrupt not gated by flag and enables");
    read_lat_a: assert property (SPR_REQ.rd && SPR_REQ.num == SPR_TBL_RD
        |=> SPR_RVALID && SPR_RDATA == $past(st_r.time_base_lower_half))
        else $error("lower half read returned wrong value");

    carry_c: cover property (tick && st_r.time_base_lower_half == ONES_32);
    reload_c: cover property (tick && st_r.dec == ONE_32 && st_r.are);
    irq_c: cover property (DEC_IRQ ##1 clr_wr);
    ext_c: cover property (tick && st_r.tick_sel == SRC_EXT);

endmodule

`default_nettype wire

// ==== verification/ctb_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Core register mover
// ****************
module ctb_core_model
    import ctb_pkg::*;
(
    // Clock
    input  wire logic                  MCLK,
    // Register moves
    output var  ctb_pkg::ctb_spr_req_t SPR_REQ,
    input  wire logic [31:0]           SPR_RDATA,
    input  wire logic                  SPR_RVALID
);
    initial SPR_REQ = '0;
    task automatic wr(input logic [9:0] n, input logic [31:0] d, input logic p);
        @(posedge MCLK);
        SPR_REQ <= '{rd: 1'b0, wr: 1'b1, priv: p, num: n, wdata: d};
    endtask
    task automatic idle();
        @(posedge MCLK);
        SPR_REQ <= '0;
    endtask
    // Answer lands on the taking edge
    task automatic rd(input logic [9:0] n, output logic [31:0] d, output logic v);
        @(posedge MCLK);
        SPR_REQ <= '{rd: 1'b1, wr: 1'b0, priv: 1'b0, num: n, wdata: 32'h0000_0000};
        @(posedge MCLK);
        SPR_REQ <= '0;
        #1;
        d = SPR_RDATA;
        v = SPR_RVALID;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ctb_pkg::*;
    logic         MCLK = 1'b0;
    logic         RESET = 1'b1;
    logic         TICK_IN = 1'b0;
    logic         EXT_IRQ_EN = 1'b0;
    ctb_spr_req_t SPR_REQ;
    logic [31:0]  SPR_RDATA;
    logic         SPR_RVALID;
    logic         DEC_IRQ;
    int           n_fail = 0;
    int           num_checks = 0;
    int           cycles = 0;
    always #20 MCLK = ~MCLK;
    ctb_time_base uut (.MCLK(MCLK), .RESET(RESET), .SPR_REQ(SPR_REQ), .SPR_RDATA(SPR_RDATA),
        .SPR_RVALID(SPR_RVALID), .TICK_IN(TICK_IN), .EXT_IRQ_EN(EXT_IRQ_EN), .DEC_IRQ(DEC_IRQ));
    ctb_core_model core (.MCLK(MCLK), .SPR_REQ(SPR_REQ), .SPR_RDATA(SPR_RDATA), .SPR_RVALID(SPR_RVALID));
    // ****************
    // Checks
    // ****************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        #1;
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic chk_rd(input logic [9:0] n, input logic [31:0] exp);
        logic [31:0] d;
        logic        v;
        core.rd(n, d, v);
        chk32({31'h0, v}, 32'h0000_0001);
        chk32(d, exp);
    endtask
    // Exactly n ticks at the clock rate
    task automatic run(input int n);
        core.wr(SPR_HWCFG, 32'h0000_0001, 1'b1);
        repeat (n - 1) @(posedge MCLK);
        core.wr(SPR_HWCFG, 32'h0000_0000, 1'b1);
        core.idle();
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_carry();
        core.wr(SPR_DOWN_CNT, 32'h0000_0000, 1'b1);
        core.wr(SPR_TBL_WR, 32'hFFFF_FFFE, 1'b1);
        core.wr(SPR_TBU_WR, 32'h0000_0012, 1'b1);
        run(3);
        chk_rd(SPR_TBL_RD, 32'h0000_0001);
        chk_rd(SPR_TBU_RD, 32'h0000_0013);
        core.wr(SPR_TBL_WR, 32'h0000_0055, 1'b0);
        core.idle();
        chk_rd(SPR_TBL_RD, 32'h0000_0001);
        chk_rd(SPR_TBL_RD, 32'h0000_0001);
        $display("test carry done");
    endtask
    task automatic t_wrap();
        core.wr(SPR_TBL_WR, 32'hFFFF_FFFF, 1'b1);
        core.wr(SPR_TBU_WR, 32'hFFFF_FFFF, 1'b1);
        run(1);
        chk_rd(SPR_TBL_RD, 32'h0000_0000);
        chk_rd(SPR_TBU_RD, 32'h0000_0000);
        chk_rd(SPR_TSTAT, 32'h0000_0000);
        $display("test wrap done");
    endtask
    task automatic t_one_shot();
        EXT_IRQ_EN <= 1'b1;
        core.wr(SPR_TCTRL, 32'h0000_0002, 1'b1);
        core.wr(SPR_DOWN_CNT, 32'h0000_0003, 1'b1);
        run(2);
        chk_rd(SPR_DOWN_CNT, 32'h0000_0001);
        chk1(DEC_IRQ, 1'b0);
        run(1);
        chk_rd(SPR_TSTAT, 32'h0000_0001);
        chk1(DEC_IRQ, 1'b1);
        run(4);
        chk_rd(SPR_DOWN_CNT, 32'h0000_0000);
        core.wr(SPR_TSTAT, 32'h0000_0000, 1'b1);
        core.idle();
        chk_rd(SPR_TSTAT, 32'h0000_0001);
        EXT_IRQ_EN <= 1'b0;
        repeat (3) @(posedge MCLK);
        chk1(DEC_IRQ, 1'b0);
        core.wr(SPR_TSTAT, 32'h0000_0001, 1'b1);
        core.idle();
        chk_rd(SPR_TSTAT, 32'h0000_0000);
        $display("test one shot done");
    endtask
    task automatic t_reload();
        core.wr(SPR_TCTRL, 32'h0000_0001, 1'b1);
        core.wr(SPR_RELOAD, 32'h0000_000A, 1'b1);
        core.wr(SPR_DOWN_CNT, 32'h0000_0002, 1'b1);
        run(2);
        chk_rd(SPR_DOWN_CNT, 32'h0000_000A);
        chk_rd(SPR_TSTAT, 32'h0000_0001);
        run(3);
        chk_rd(SPR_DOWN_CNT, 32'h0000_0007);
        chk_rd(SPR_RELOAD, 32'h0000_000A);
        core.wr(SPR_TSTAT, 32'h0000_0001, 1'b1);
        core.wr(SPR_DOWN_CNT, 32'h0000_0000, 1'b1);
        run(2);
        chk_rd(SPR_TSTAT, 32'h0000_0000);
        $display("test reload done");
    endtask
    task automatic t_ext_tick();
        core.wr(SPR_TBL_WR, 32'h0000_0000, 1'b1);
        core.wr(SPR_HWCFG, 32'h0000_0007, 1'b1);
        core.idle();
        repeat (2) begin
            @(posedge MCLK);
            TICK_IN <= 1'b1;
            repeat (2) @(posedge MCLK);
            TICK_IN <= 1'b0;
            repeat (2) @(posedge MCLK);
        end
        core.wr(SPR_HWCFG, 32'h0000_0000, 1'b1);
        core.idle();
        TICK_IN <= 1'b1;
        repeat (5) @(posedge MCLK);
        chk_rd(SPR_TBL_RD, 32'h0000_0002);
        $display("test external tick done");
    endtask
    task automatic t_div();
        core.wr(SPR_TBL_WR, 32'h0000_0000, 1'b1);
        core.wr(SPR_HWCFG, 32'h0000_0003, 1'b1);
        repeat (7) @(posedge MCLK);
        core.wr(SPR_HWCFG, 32'h0000_0000, 1'b1);
        core.idle();
        chk_rd(SPR_TBL_RD, 32'h0000_0002);
        core.wr(SPR_TBL_WR, 32'h0000_0000, 1'b1);
        core.wr(SPR_HWCFG, 32'h0000_0005, 1'b1);
        repeat (31) @(posedge MCLK);
        core.wr(SPR_HWCFG, 32'h0000_0000, 1'b1);
        core.idle();
        chk_rd(SPR_TBL_RD, 32'h0000_0001);
        $display("test divided tick done");
    endtask
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge MCLK);
        RESET <= 1'b0;
        core.idle();
        t_carry();
        t_wrap();
        t_one_shot();
        t_reload();
        t_ext_tick();
        t_div();
        wrap_up();
    end
endmodule
`default_nettype wire
